/* sbtm_mode_regs.sv */
// bus transceiver mode registers and watchdog period tail
// assumes a 16-bit serial host and power-mode inputs from the state machine
`timescale 1ns/100ps
`default_nettype none
`include "sbtm_defs.svh"
module sbtm_mode_regs
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial pins
    input wire logic csN,
    input wire logic sclk,
    input wire logic mosi,
    output logic misoOut,
    output logic misoOe,
    // chip state
    input wire logic restart,
    input wire logic stopMode,
    input wire logic sleepMode,
    // watchdog events
    input wire logic wdFail,
    input wire logic wdServiced,
    output logic wdResetPulse,
    output logic [9:0] watchdogPeriodMs,
    output logic watchdogPeriodReserved,
    // transceiver controls
    output sbtm_pkg::sbtm_modes_t modes,
    output logic linSlopeControlOn,
    output logic lin_slope_select,
    output logic lin_transmit_timeout_enable,
    output logic high_boost_level
);
    import sbtm_pkg::*;

    logic [7:0] bus1_reg;
    logic [7:0] bus2_reg;
    logic [3:0] wd_reg;
    logic [1:0] wdCount_reg;
    logic [6:0] readAddr;
    logic [7:0] readData;
    sbtm_frame_t frame;
    logic frameValid;
    sbtm_modes_t modes_next;
    logic [9:0] periodMs;

    ////////////////////////////////////////////////////////////////////
    // frame receiver
    sbtm_spi_frame u_frame
    (
        .clk(clk),
        .rst(rst),
        .csN(csN),
        .sclk(sclk),
        .mosi(mosi),
        .misoOut(misoOut),
        .misoOe(misoOe),
        .readAddr(readAddr),
        .readData(readData),
        .frame(frame),
        .frameValid(frameValid)
    );

    // write decode and read mux
    wire wrWd = frameValid && frame.write && frame.addr == `SBTM_ADDR_WD;
    wire wrBus1 = frameValid && frame.write && frame.addr == `SBTM_ADDR_BUS1;
    wire wrBus2 = frameValid && frame.write && frame.addr == `SBTM_ADDR_BUS2;
    assign readData = (readAddr == `SBTM_ADDR_WD) ? {4'h0, wd_reg} :
                      (readAddr == `SBTM_ADDR_BUS1) ? bus1_reg :
                      (readAddr == `SBTM_ADDR_BUS2) ? bus2_reg : 8'h00;
    wire [7:0] bus1_next = frame.data & `SBTM_BUS_MASK;
    wire [7:0] bus2_wr = wrBus2 ? (frame.data & `SBTM_BUS_MASK) : bus2_reg;
    wire [7:0] bus2_next = restart ? (bus2_wr & `SBTM_BUS2_RESTART_MASK) : bus2_wr;
    wire [3:0] wd_wr = wrWd ? frame.data[3:0] : wd_reg;
    wire [3:0] wd_next = restart ? {wd_wr[3], `SBTM_WD_RESTART_PER} : wd_wr;

    ////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus1_reg <= `SBTM_BUS1_RST;
            bus2_reg <= `SBTM_BUS2_RST;
            wd_reg <= `SBTM_WD_RST;
        end
        else
        begin
            if (wrBus1)
                bus1_reg <= bus1_next;
            bus2_reg <= bus2_next;
            wd_reg <= wd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // effective modes: normal falls back to wake in stop or sleep
    wire lowPower = stopMode || sleepMode;
    // stored codes in the order of the modes struct, can first
    wire logic [`SBTM_NUM_XCVR-1:0][`SBTM_MODE_W-1:0] storedMode = {
        bus1_reg[`SBTM_CAN_LSB +: `SBTM_MODE_W],
        bus1_reg[`SBTM_FIRST_LIN_CHANNEL_MODE_LSB +: `SBTM_MODE_W],
        bus2_reg[`SBTM_SECOND_LIN_CHANNEL_MODE_LSB +: `SBTM_MODE_W],
        bus2_reg[`SBTM_THIRD_LIN_CHANNEL_MODE_LSB +: `SBTM_MODE_W],
        bus2_reg[`SBTM_FOURTH_LIN_CHANNEL_MODE_LSB +: `SBTM_MODE_W]};
    wire logic [`SBTM_NUM_XCVR-1:0][`SBTM_MODE_W-1:0] effMode;
    // per channel fallback, stored code itself left alone
    for (genvar ch = 0; ch < `SBTM_NUM_XCVR; ch++)
    begin : g_fallback
        assign effMode[ch] = (lowPower && storedMode[ch] == `SBTM_MODE_NORMAL) ?
            `SBTM_MODE_WAKE : storedMode[ch];
    end
    assign modes_next = effMode;

    // watchdog period lookup
    always_comb
    begin
        unique case (wd_reg[2:0])
            3'h0: periodMs = `SBTM_WD_MS_0;
            3'h1: periodMs = `SBTM_WD_MS_1;
            3'h2: periodMs = `SBTM_WD_MS_2;
            3'h3: periodMs = `SBTM_WD_MS_3;
            3'h4: periodMs = `SBTM_WD_MS_4;
            3'h5: periodMs = `SBTM_WD_MS_5;
            3'h6: periodMs = `SBTM_WD_MS_6;
            3'h7: periodMs = `SBTM_WD_MS_NONE;
        endcase
    end

    // watchdog reset limiting
    wire limitOn = wd_reg[`SBTM_LIMIT_BIT];
    wire issueReset = wdFail && (!limitOn || wdCount_reg < `SBTM_WD_MAX_RESETS);

    ////////////////////////////////////////////////////////////////////
    // registered outputs (stored fields untouched by fallback)
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            modes <= '0;
            linSlopeControlOn <= 1'b1;
            lin_slope_select <= 1'b0;
            lin_transmit_timeout_enable <= 1'b1;
            high_boost_level <= 1'b0;
            watchdogPeriodMs <= `SBTM_WD_MS_4;
            watchdogPeriodReserved <= 1'b0;
            wdResetPulse <= 1'b0;
            wdCount_reg <= 2'h0;
        end
        else
        begin
            modes <= modes_next;
            linSlopeControlOn <= !bus1_reg[`SBTM_FLASH_BIT];
            lin_slope_select <= bus1_reg[`SBTM_SLOPE_BIT];
            lin_transmit_timeout_enable <= bus1_reg[`SBTM_TXTO_BIT];
            high_boost_level <= bus2_reg[`SBTM_BOOSTH_BIT];
            watchdogPeriodMs <= periodMs;
            watchdogPeriodReserved <= (wd_reg[2:0] == `SBTM_WD_CODE_RSVD);
            wdResetPulse <= issueReset;
            if (wdServiced)
                wdCount_reg <= {1'b0, issueReset}; // a reset in the same cycle still counts
            else if (issueReset && wdCount_reg != `SBTM_WD_MAX_RESETS)
                wdCount_reg <= wdCount_reg + 2'h1;
        end
    end
endmodule // sbtm_mode_regs
`default_nettype wire

/* sbtm_defs.svh */
// constants of the bus transceiver mode register slice
// assumes inclusion by bare name from the package and design files
`ifndef SBTM_DEFS_SVH
`define SBTM_DEFS_SVH

// register addresses (7-bit)
`define SBTM_ADDR_WD 7'h03
`define SBTM_ADDR_BUS1 7'h04
`define SBTM_ADDR_BUS2 7'h05

// frame layout: bits 6:0 address, bit 7 write, bits 15:8 data, LSB first
`define SBTM_FRAME_BITS 5'h10
`define SBTM_HDR_BITS 5'h08

// reset values
`define SBTM_BUS1_RST 8'h20
`define SBTM_BUS2_RST 8'h00
`define SBTM_WD_RST 4'h4
`define SBTM_WD_RESTART_PER 3'h4

// writable and restart masks (reserved bit 2 excluded; the restart mask also clears bit 5)
`define SBTM_BUS_MASK 8'hFB
`define SBTM_BUS2_RESTART_MASK 8'hDB

// field positions
`define SBTM_FLASH_BIT 7
`define SBTM_SLOPE_BIT 6
`define SBTM_TXTO_BIT 5
`define SBTM_BOOSTH_BIT 5
`define SBTM_LIMIT_BIT 3

// transceiver mode field positions and count
`define SBTM_CAN_LSB 0
`define SBTM_FIRST_LIN_CHANNEL_MODE_LSB 3
`define SBTM_SECOND_LIN_CHANNEL_MODE_LSB 0
`define SBTM_THIRD_LIN_CHANNEL_MODE_LSB 3
`define SBTM_FOURTH_LIN_CHANNEL_MODE_LSB 6
`define SBTM_MODE_W 2
`define SBTM_NUM_XCVR 5
`define SBTM_WD_CODE_RSVD 3'h7

// transceiver modes
`define SBTM_MODE_WAKE 2'h1
`define SBTM_MODE_NORMAL 2'h3

// watchdog limit and period table in ms
`define SBTM_WD_MAX_RESETS 2'h3
`define SBTM_WD_MS_0 10'h00A
`define SBTM_WD_MS_1 10'h014
`define SBTM_WD_MS_2 10'h032
`define SBTM_WD_MS_3 10'h064
`define SBTM_WD_MS_4 10'h0C8
`define SBTM_WD_MS_5 10'h1F4
`define SBTM_WD_MS_6 10'h3E8
`define SBTM_WD_MS_NONE 10'h000

`endif

/* sbtm_pkg.sv */
// types shared by the frame receiver and the register slice
// assumes sbtm_defs.svh on the include path
`include "sbtm_defs.svh"
package sbtm_pkg;
    // one received command frame
    typedef struct packed {
        logic write;
        logic [6:0] addr;
        logic [7:0] data;
    } sbtm_frame_t;

    // effective transceiver modes handed to the analog side
    typedef struct packed {
        logic [1:0] can;
        logic [1:0] first_lin_channel_mode;
        logic [1:0] second_lin_channel_mode;
        logic [1:0] third_lin_channel_mode;
        logic [1:0] fourth_lin_channel_mode;
    } sbtm_modes_t;
endpackage

/* sbtm_spi_frame.sv */
// 16-bit serial frame receiver, LSB first, data applied at frame end
// assumes pins synchronous to clk; sample on rising, shift out on falling
`timescale 1ns/100ps
`default_nettype none
`include "sbtm_defs.svh"
module sbtm_spi_frame
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial pins
    input wire logic csN,
    input wire logic sclk,
    input wire logic mosi,
    output logic misoOut,
    output logic misoOe,
    // register side
    output logic [6:0] readAddr,
    input wire logic [7:0] readData,
    output sbtm_pkg::sbtm_frame_t frame,
    output logic frameValid
);
    import sbtm_pkg::*;

    logic sclkPrev_reg;
    logic [4:0] bitCnt_reg;
    logic [15:0] rxShift_reg;
    logic [7:0] txShift_reg;

    // edge decode
    wire active = !csN;
    wire riseEdge = active && sclk && !sclkPrev_reg;
    wire fallEdge = active && !sclk && sclkPrev_reg;
    wire [15:0] rxNext = {mosi, rxShift_reg[15:1]};
    wire frameEnd = csN && (bitCnt_reg != 5'h00);
    wire frameGood = frameEnd && (bitCnt_reg == `SBTM_FRAME_BITS);

    ////////////////////////////////////////////////////////////////////
    // receive side
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sclkPrev_reg <= 1'b0;
            bitCnt_reg <= 5'h00;
            rxShift_reg <= 16'h0000;
            readAddr <= 7'h00;
            frame <= '0;
            frameValid <= 1'b0;
        end
        else
        begin
            sclkPrev_reg <= sclk;
            frameValid <= frameGood;
            if (frameGood)
                frame <= {rxShift_reg[7], rxShift_reg[6:0], rxShift_reg[15:8]};
            if (frameEnd)
                bitCnt_reg <= 5'h00; // aborted or done, count restarts
            else if (riseEdge && bitCnt_reg != 5'h1F)
            begin
                bitCnt_reg <= bitCnt_reg + 5'h01;
                rxShift_reg <= rxNext;
                if (bitCnt_reg == 5'h06)
                    readAddr <= rxNext[15:9];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit side: data byte of addressed register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            txShift_reg <= 8'h00;
            misoOut <= 1'b0;
            misoOe <= 1'b0;
        end
        else
        begin
            misoOe <= active;
            if (!active)
                misoOut <= 1'b0;
            else if (fallEdge && bitCnt_reg == `SBTM_HDR_BITS)
            begin
                txShift_reg <= {1'b0, readData[7:1]};
                misoOut <= readData[0];
            end
            else if (fallEdge && bitCnt_reg > `SBTM_HDR_BITS)
            begin
                txShift_reg <= {1'b0, txShift_reg[7:1]};
                misoOut <= txShift_reg[0];
            end
        end
    end
endmodule // sbtm_spi_frame
`default_nettype wire

/* sbtm_host_model.sv */
// host model: drives serial frames LSB first, reads the data byte back
// assumes clk at 200 MHz; sclk high and low two clocks each
`timescale 1ns/100ps
`default_nettype none
module sbtm_host_model
(
    // clock
    input wire logic clk,
    // serial pins
    output logic csN,
    output logic sclk,
    output logic mosi,
    input wire logic misoOut
);
    // idle pins
    initial
    begin
        csN = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    // one frame of nBits bits
    task automatic xfer(input logic [15:0] tx, input int nBits, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk) #1 csN = 1'b0;
        for (int i = 0; i < nBits; i++)
        begin
            mosi = tx[i];
            repeat (2) @(posedge clk);
            #1 sclk = 1'b1;
            if (i > 7) rd[i-8] = misoOut;
            repeat (2) @(posedge clk);
            #1 sclk = 1'b0;
        end
        repeat (2) @(posedge clk);
        #1 csN = 1'b1;
        mosi = ~mosi; // released line shows no stale value
        repeat (2) @(posedge clk);
        #1;
    endtask
endmodule // sbtm_host_model
`default_nettype wire

/* sbtm_mode_regs_assertions.sv */
// checker on the ports of the mode register slice
// assumes the bind below attaches it to every instance
`timescale 1ns/100ps
`default_nettype none
module sbtm_mode_regs_checker
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire logic csN,
    input wire logic misoOut,
    input wire logic misoOe,
    input wire logic restart,
    input wire logic stopMode,
    input wire logic sleepMode,
    input wire logic wdFail,
    input wire logic wdResetPulse,
    input wire logic [9:0] watchdogPeriodMs,
    input wire logic watchdogPeriodReserved,
    input wire sbtm_pkg::sbtm_modes_t modes,
    input wire logic linSlopeControlOn,
    input wire logic lin_slope_select,
    input wire logic lin_transmit_timeout_enable,
    input wire logic high_boost_level
);
    import sbtm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // any transceiver still shown as normal
    wire logic anyNormal = &modes.can | &modes.first_lin_channel_mode | &modes.second_lin_channel_mode | &modes.third_lin_channel_mode | &modes.fourth_lin_channel_mode;
    wd_cause_a: assert property (wdResetPulse |-> $past(wdFail))
        else $error("watchdog reset without failure");
    period_table_a: assert property (watchdogPeriodMs inside {10'h00A, 10'h014, 10'h032,
        10'h064, 10'h0C8, 10'h1F4, 10'h3E8, 10'h000}) else $error("period out of table");
    period_reserved_a: assert property (watchdogPeriodReserved == (watchdogPeriodMs == 0))
        else $error("reserved flag disagrees with period");
    low_power_fallback_a: assert property ((stopMode || sleepMode) [*3] |-> !anyNormal)
        else $error("normal mode shown in low power");
    frame_only_a: assert property ($changed(lin_slope_select) |-> $past(csN, 3) && !$past(csN, 4))
        else $error("setting changed outside frame end");
    reset_values_a: assert property ($fell(rst) |-> modes == 0 && linSlopeControlOn
        && lin_transmit_timeout_enable && !high_boost_level) else $error("bad reset outputs");
    restart_clear_a: assert property (restart |-> ##3 !high_boost_level
        && watchdogPeriodMs == 10'h0C8) else $error("restart values wrong");
    miso_idle_a: assert property (csN [*2] |-> !misoOe && !misoOut)
        else $error("miso driven while deselected");
    miso_enable_a: assert property ((!csN) [*2] |-> misoOe)
        else $error("miso not enabled while selected");
endmodule // sbtm_mode_regs_checker
bind sbtm_mode_regs sbtm_mode_regs_checker chk (.clk, .rst, .csN, .misoOut, .misoOe, .restart,
    .stopMode, .sleepMode, .wdFail, .wdResetPulse, .watchdogPeriodMs, .watchdogPeriodReserved,
    .modes, .linSlopeControlOn, .lin_slope_select, .lin_transmit_timeout_enable,
    .high_boost_level);
`default_nettype wire

/* bus_transceiver_mode_regs_tb_top.sv */
// self-checking bench for the mode register slice
// assumes package, design, host model and checker compiled before it
`timescale 1ns/100ps
`default_nettype none
module bus_transceiver_mode_regs_tb_top;
    import sbtm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic restart = 1'b0;
    logic stopMode = 1'b0;
    logic sleepMode = 1'b0;
    logic wdFail = 1'b0;
    logic wdServiced = 1'b0;
    wire logic csN, sclk, mosi, misoOut, misoOe, wdResetPulse, watchdogPeriodReserved;
    wire logic linSlopeControlOn, lin_slope_select, lin_transmit_timeout_enable, high_boost_level;
    wire logic [9:0] watchdogPeriodMs;
    wire sbtm_modes_t modes;
    int miscompares = 0;
    int n_compared = 0;
    int hits;
    logic [7:0] rd, d1, d2;
    logic [9:0] msTable [8] = '{10'h00A, 10'h014, 10'h032, 10'h064, 10'h0C8, 10'h1F4, 10'h3E8,
        10'h000};
    // 200 MHz clock
    always #2.5 clk = ~clk;
    sbtm_mode_regs uut (.clk, .rst, .csN, .sclk, .mosi, .misoOut, .misoOe, .restart, .stopMode,
        .sleepMode, .wdFail, .wdServiced, .wdResetPulse, .watchdogPeriodMs, .watchdogPeriodReserved,
        .modes, .linSlopeControlOn, .lin_slope_select, .lin_transmit_timeout_enable,
        .high_boost_level);
    sbtm_host_model host (.clk, .csN, .sclk, .mosi, .misoOut);
    // expected effective modes from the two register bytes
    function automatic logic [9:0] expModes(input logic [7:0] b1, input logic [7:0] b2);
        return {b1[1:0], b1[4:3], b2[1:0], b2[4:3], b2[7:6]};
    endfunction
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({d, 1'b1, a}, 16, rd);
        tick(4);
    endtask
    task automatic rdr(input logic [6:0] a);
        host.xfer({8'h00, 1'b0, a}, 16, rd);
    endtask
    task automatic wdKick(input int n);
        hits = 0;
        repeat (n)
        begin
            @(posedge clk) #1 wdFail = 1'b1;
            @(posedge clk) #1 wdFail = 1'b0;
            hits += int'(wdResetPulse === 1'b1);
            @(posedge clk) #1;
        end
    endtask
    task automatic summarize();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial
    begin
        void'($urandom(11));
        tick(16);
        rst = 1'b0;
        rdr(7'h04);
        chk("bus1", 10'h020, {2'h0, rd});
        rdr(7'h10);
        chk("unmapped", 10'h000, {2'h0, rd});
        $display("reset test done");
        for (int i = 0; i < 8; i++)
        begin
            d1 = (i == 0) ? 8'hFF : 8'($urandom);
            d2 = (i == 1) ? 8'hFF : 8'($urandom);
            wr(7'h04, d1);
            wr(7'h05, d2);
            chk("modes", expModes(d1, d2), modes);
            chk("flags", {6'h00, ~d1[7], d1[6:5], d2[5]}, {6'h00, linSlopeControlOn,
                lin_slope_select, lin_transmit_timeout_enable, high_boost_level});
            rdr(7'h05);
            chk("bus2", {2'h0, d2 & 8'hFB}, {2'h0, rd});
        end
        host.xfer({~d1, 1'b1, 7'h04}, 12, rd);
        host.xfer({~d1, 1'b0, 7'h04}, 16, rd);
        rdr(7'h04);
        chk("bus1", {2'h0, d1 & 8'hFB}, {2'h0, rd});
        $display("field test done");
        for (int c = 0; c < 8; c++)
        begin
            wr(7'h03, 8'(c));
            chk("period", msTable[c], watchdogPeriodMs);
            chk("reserved", {9'h000, c == 7}, {9'h000, watchdogPeriodReserved});
        end
        wr(7'h03, 8'h08);
        wdKick(4);
        chk("limited", 10'h003, 10'(hits));
        @(posedge clk) #1 wdServiced = 1'b1;
        @(posedge clk) #1 wdServiced = 1'b0;
        wdKick(1);
        chk("serviced", 10'h001, 10'(hits));
        wr(7'h03, 8'h00);
        wdKick(4);
        chk("unlimited", 10'h004, 10'(hits));
        $display("watchdog test done");
        wr(7'h04, 8'h1B);
        wr(7'h05, 8'hDB);
        stopMode = 1'b1;
        tick(4);
        chk("stop", 10'h155, modes);
        rdr(7'h04);
        chk("held", 10'h01B, {2'h0, rd});
        stopMode = 1'b0;
        tick(4);
        chk("resume", 10'h3FF, modes);
        wr(7'h04, 8'h11);
        sleepMode = 1'b1;
        tick(4);
        chk("sleep", 10'h195, modes);
        sleepMode = 1'b0;
        $display("low power test done");
        wr(7'h05, 8'hFF);
        wr(7'h03, 8'h0A);
        restart = 1'b1;
        tick(1);
        restart = 1'b0;
        tick(3);
        rdr(7'h05);
        chk("bus2", 10'h0DB, {2'h0, rd});
        rdr(7'h03);
        chk("wd", 10'h00C, {2'h0, rd});
        $display("restart test done");
        summarize();
    end
endmodule // bus_transceiver_mode_regs_tb_top
`default_nettype wire
